// ==== inc/sbs_pkg.sv ====
// Behaviour
// - Sample on TCK rise, launch on fall
// - Undriven TMS reads as one
// - Undriven TDI shifts in ones
// - TDO driven only while shifting, falls only
// - Five TMS-high rises reach Test-Logic-Reset
// - Power-up resets the TAP controller
// - Port inactive until TCK is applied
// - Registers shift on rise, output on fall
// - Exactly one register between TDI and TDO
// - Instruction register is three bits
// - Identification instruction loaded on reset
// - One-bit bypass register, one stage delay
// - Capture-DR samples pins into boundary chain
// - Unbonded boundary cells always capture one
// - Boundary chain only for three instructions
// - Identification code captured, shifted in Shift-DR
// - Identification shifts out bit zero first
// - Capture-IR loads 01 into low bits
// - Shift-IR shifts instruction in, captured bits out
// - New instruction acts only at Update-IR
// - Held instruction acts in idle, DR states
// - Instruction codes 000,001,010,100,111
// - Reserved codes behave as bypass
// - Sample-floated floats memory outputs
package sbs_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int PIN_W = 16;
  localparam int PAD_W = 4;
  localparam int BSR_W = PIN_W + PAD_W;
  localparam int LINK_W = 3;

  typedef logic [IR_W-1:0] sbs_ir_t;

  // Instruction codes, MSB first
  localparam sbs_ir_t INS_EXTEST = 3'h0;
  localparam sbs_ir_t INS_IDCODE = 3'h1;
  localparam sbs_ir_t INS_SAMPLE_Z = 3'h2;
  localparam sbs_ir_t INS_PRELOAD = 3'h4;
  localparam sbs_ir_t INS_BYPASS = 3'h7;

  // Low instruction bits seen on every capture
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam sbs_ir_t IR_RST = INS_IDCODE;

  // Identification code, value is arbitrary
  localparam logic [ID_W-1:0] ID_CODE = 32'h0A5C_3001;

  // Level captured by cells with no pin behind them
  localparam logic PAD_VALUE = 1'h1;

  // Synchroniser reset levels, order {tdi, tms, tck}
  localparam logic [LINK_W-1:0] LINK_RST = 3'h6;
  localparam logic [PIN_W-1:0] PIN_RST = 16'h0000;

  // TMS-high rising edges that always reach reset
  localparam int TLR_TMS_ONES = 5;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbs_tap_e;

endpackage

// ==== inc/sbs_tap_if.sv ====
`timescale 1ns/1ns
// Carries the sampled TCK edge and TMS to the controller, state back
interface sbs_tap_if;
  import sbs_pkg::*;
  logic tck_rise;
  logic tms;
  sbs_tap_e state;
  modport core (output tck_rise, output tms, input state);
  modport fsm (input tck_rise, input tms, output state);
endinterface

// ==== design/sbs_sync.sv ====
`timescale 1ns/1ns
// Three-stage synchroniser; a level counts once stages two and three agree
module sbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic [W-1:0] d_i, // Asynchronous levels
  output logic [W-1:0] q_o // Filtered levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sbs_sync_s;

  sbs_sync_s r;
  sbs_sync_s next_r;
  logic [W-1:0] agree_q;

  // Stage one feeds only stage two, so no gate sees a metastable level
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree_q[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
  end

  // Shift the chain and hold the filtered level
  always_comb begin
    next_r = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = agree_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r <= '{s1: RST, s2: RST, s3: RST, q: RST};
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;
endmodule

// ==== design/sbs_tap_fsm.sv ====
`timescale 1ns/1ns
// Sixteen-state TAP controller, stepped on each sampled TCK rise
module sbs_tap_fsm (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, high
  sbs_tap_if.fsm tap // Edge and TMS in, state out
);
  import sbs_pkg::*;

  typedef struct packed {
    sbs_tap_e state;
  } sbs_fsm_s;

  sbs_fsm_s r;
  sbs_fsm_s next_r;

  // TMS picks every transition; five ones reach reset from anywhere
  always_comb begin
    next_r = r;
    if (tap.tck_rise) begin
      case (r.state)
        ST_TLR: next_r.state = tap.tms ? ST_TLR : ST_RTI;
        ST_RTI: next_r.state = tap.tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: next_r.state = tap.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_r.state = tap.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: next_r.state = tap.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_r.state = tap.tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: next_r.state = tap.tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: next_r.state = tap.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: next_r.state = tap.tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: next_r.state = tap.tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: next_r.state = tap.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: next_r.state = tap.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_r.state = tap.tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: next_r.state = tap.tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: next_r.state = tap.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: next_r.state = tap.tms ? ST_SEL_DR : ST_RTI;
        default: next_r.state = ST_TLR;
      endcase
    end
  end

  // Power-up reset puts the controller in Test-Logic-Reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r.state <= ST_TLR;
    end else begin
      r <= next_r;
    end
  end

  assign tap.state = r.state;
endmodule

// ==== design/sbs_tap_top.sv ====
`timescale 1ns/1ns
// Boundary-scan test port: TAP, instruction, bypass, ID and boundary chain
module sbs_tap_top (
  input wire logic sys_clk_i, // System clock, 25 MHz
  input wire logic sys_rst_i, // Power-up reset, synchronous, high
  input wire logic tck_i, // Test clock pin
  input wire logic tms_i, // Test mode select pin
  input wire logic tms_drv_i, // High while someone drives TMS
  input wire logic tdi_i, // Test data in pin
  input wire logic tdi_drv_i, // High while someone drives TDI
  output logic tdo_o, // Test data out
  output logic tdo_oe_o, // TDO output enable, high drives
  input wire logic [sbs_pkg::PIN_W-1:0] pin_i, // Memory pin levels
  output logic mem_float_o, // Force memory outputs high-Z
  output logic extest_o, // Memory outputs take boundary data
  output logic [sbs_pkg::PIN_W-1:0] extest_data_o // Boundary drive data
);
  import sbs_pkg::*;

  typedef struct packed {
    logic tck_q;
    sbs_ir_t ir;
    sbs_ir_t ir_sh;
    logic byp;
    logic [ID_W-1:0] idr;
    logic [BSR_W-1:0] bsr;
    logic [PIN_W-1:0] upd;
    logic tdo;
    logic tdo_oe;
  } sbs_core_s;

  sbs_core_s r;
  sbs_core_s next_r;
  sbs_tap_if tap ();
  logic [LINK_W-1:0] link_raw;
  logic [LINK_W-1:0] link_q;
  logic [PIN_W-1:0] pin_q;
  logic tck_f;
  logic tms_f;
  logic tdi_f;
  logic rise;
  logic fall;
  logic sel_bsr;
  logic sel_id;
  logic shifting;
  logic sel_bit;

  // A floating pin is taken as high, as the pad pull-up would make it
  assign link_raw[2] = tdi_drv_i ? tdi_i : 1'h1;
  assign link_raw[1] = tms_drv_i ? tms_i : 1'h1;
  assign link_raw[0] = tck_i;

  sbs_sync #(.W(LINK_W), .RST(LINK_RST)) u_link_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(link_raw),
    .q_o(link_q)
  );

  // Memory pins run on their own clock; samples may be unstable if moving
  sbs_sync #(.W(PIN_W), .RST(PIN_RST)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(pin_i),
    .q_o(pin_q)
  );

  assign tdi_f = link_q[2];
  assign tms_f = link_q[1];
  assign tck_f = link_q[0];

  // TCK edges; nothing moves until TCK really toggles
  assign rise = tck_f & ~r.tck_q;
  assign fall = ~tck_f & r.tck_q;

  assign tap.tck_rise = rise;
  assign tap.tms = tms_f;

  sbs_tap_fsm u_fsm (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .tap(tap)
  );

  // Data register choice; every other code falls to bypass
  always_comb begin
    sel_bsr = 1'h0;
    sel_id = 1'h0;
    case (r.ir)
      INS_EXTEST, INS_SAMPLE_Z, INS_PRELOAD: sel_bsr = 1'h1;
      INS_IDCODE: sel_id = 1'h1;
      default: sel_bsr = 1'h0;
    endcase
  end

  // Exactly one register feeds TDO, chosen by state and instruction
  always_comb begin
    shifting = 1'h0;
    sel_bit = r.byp;
    case (tap.state)
      ST_SH_IR: begin
        shifting = 1'h1;
        sel_bit = r.ir_sh[0];
      end
      ST_SH_DR: begin
        shifting = 1'h1;
        if (sel_bsr) begin
          sel_bit = r.bsr[0];
        end else if (sel_id) begin
          sel_bit = r.idr[0];
        end else begin
          sel_bit = r.byp;
        end
      end
      default: shifting = 1'h0;
    endcase
  end

  // Capture and shift on the rise, launch and update on the fall
  always_comb begin
    next_r = r;
    next_r.tck_q = tck_f;
    if (rise) begin
      case (tap.state)
        ST_CAP_IR: next_r.ir_sh = {r.ir[IR_W-1:2], IR_CAPTURE};
        ST_SH_IR: next_r.ir_sh = {tdi_f, r.ir_sh[IR_W-1:1]};
        ST_CAP_DR: begin
          next_r.byp = 1'h0;
          if (sel_id) begin
            next_r.idr = ID_CODE;
          end
          if (sel_bsr) begin
            next_r.bsr = {{PAD_W{PAD_VALUE}}, pin_q};
          end
        end
        ST_SH_DR: begin
          if (sel_bsr) begin
            next_r.bsr = {tdi_f, r.bsr[BSR_W-1:1]};
          end else if (sel_id) begin
            next_r.idr = {tdi_f, r.idr[ID_W-1:1]};
          end else begin
            next_r.byp = tdi_f;
          end
        end
        default: next_r.byp = r.byp;
      endcase
    end
    if (fall) begin
      next_r.tdo_oe = shifting;
      if (shifting) begin
        next_r.tdo = sel_bit;
      end
      if (tap.state == ST_UPD_IR) begin
        next_r.ir = r.ir_sh;
      end
      if (tap.state == ST_UPD_DR && sel_bsr) begin
        next_r.upd = r.bsr[PIN_W-1:0];
      end
    end
    // Reset state holds the default instruction every cycle
    if (tap.state == ST_TLR) begin
      next_r.ir = IR_RST;
      next_r.ir_sh = IR_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r <= '{tck_q: 1'h0, ir: IR_RST, ir_sh: IR_RST, byp: 1'h0,
             idr: '0, bsr: '0, upd: '0, tdo: 1'h0, tdo_oe: 1'h0};
    end else begin
      r <= next_r;
    end
  end

  // Held instruction steers the memory pins; it changes only at Update-IR or in Test-Logic-Reset
  assign mem_float_o = (r.ir == INS_SAMPLE_Z);
  assign extest_o = (r.ir == INS_EXTEST);
  assign extest_data_o = r.upd;
  assign tdo_o = r.tdo;
  assign tdo_oe_o = r.tdo_oe;
endmodule

// ==== verification/sbs_jtag_model.sv ====
`timescale 1ns/1ns
// Test controller; TCK rests low between steps, a step is 8 clocks
module sbs_jtag_model (
  input wire logic clk_i, // Bench clock
  input wire logic tdo_i, // Serial out
  input wire logic tdo_oe_i, // Out enable
  output logic tck_o, // Test clock
  output logic tms_o, // Mode select
  output logic tdi_o // Serial in
);
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h1;
  end
  // TMS/TDI held four clocks both sides of the rise, as the sync needs
  task automatic step(input logic m, input logic d, output logic [1:0] q);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'h1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) q = {tdo_oe_i, tdo_i};
    repeat (2) @(posedge clk_i);
    tck_o <= 1'h0;
  endtask
endmodule

// ==== verification/sbs_tap_chk.sv ====
`timescale 1ns/1ns
// Watches the test port at the top's pins
module sbs_tap_chk (
  input wire logic sys_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic tck_i, // Test clock
  input wire logic tms_i, // Mode select
  input wire logic tms_drv_i, // Mode driven
  input wire logic tdo_o, // Serial out
  input wire logic tdo_oe_o, // Out enable
  input wire logic mem_float_o, // Outputs off
  input wire logic extest_o, // Chain drives
  input wire logic [sbs_pkg::PIN_W-1:0] extest_data_o // Drive data
);
  logic [1:0] tq;
  logic [2:0] ones;
  logic seen;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Count TMS-high rises, floating TMS as high; saturates at five
  always_ff @(posedge sys_clk_i) begin
    tq <= sys_rst_i ? 2'h0 : {tq[0], tck_i};
    seen <= !sys_rst_i & (seen | tck_i);
    if (sys_rst_i || (tq == 2'h1 && !(tms_i | !tms_drv_i))) begin
      ones <= 3'h0;
    end else if (tq == 2'h1 && ones != 3'h5) begin
      ones <= ones + 3'h1;
    end
  end
  // Launches must trail a fall; a rise-driven slip lands with TCK high
  property p_out; $changed(tdo_o) |-> !$past(tck_i, 3); endproperty
  property p_oe; $changed(tdo_oe_o) |-> !$past(tck_i, 3); endproperty
  property p_ir;
    $rose(mem_float_o) || $rose(extest_o) |-> !$past(tck_i, 3);
  endproperty
  property p_bnd; $changed(extest_data_o) |-> !$past(tck_i, 3); endproperty
  property p_por; $fell(sys_rst_i) |-> !(tdo_oe_o | mem_float_o | extest_o);
  endproperty
  property p_excl; !(mem_float_o && extest_o); endproperty
  property p_tlr;
    ones == 3'h5 |-> ##[1:12] !(tdo_oe_o | mem_float_o | extest_o);
  endproperty
  property p_idle; !seen |-> !(tdo_oe_o | mem_float_o | extest_o);
  endproperty
  a_out: assert property (p_out)
    else $error("tdo moved off a fall");
  a_oe: assert property (p_oe)
    else $error("tdo enable moved off a fall");
  a_ir: assert property (p_ir)
    else $error("instruction acted off a fall");
  a_bnd: assert property (p_bnd)
    else $error("boundary data moved off a fall");
  a_por: assert property (p_por)
    else $error("outputs busy after reset");
  a_excl: assert property (p_excl)
    else $error("two instructions at once");
  a_tlr: assert property (p_tlr)
    else $error("five TMS ones did not reset");
  a_idle: assert property (p_idle)
    else $error("port active before TCK");
  c_oe: cover property ($rose(tdo_oe_o));
  c_fl: cover property ($rose(mem_float_o));
  c_ex: cover property ($rose(extest_o));
endmodule
bind sbs_tap_top sbs_tap_chk i_chk (.sys_clk_i, .sys_rst_i, .tck_i,
  .tms_i, .tms_drv_i, .tdo_o, .tdo_oe_o, .mem_float_o, .extest_o,
  .extest_data_o);

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import sbs_pkg::*;
  localparam logic [31:0] DAT = 32'h0015A5A5;
  logic clk, rst, tck, tms, tdi, tmsd, tdid, tdo, oe, fl, ex;
  logic [PIN_W-1:0] pin;
  logic [PIN_W-1:0] xd;
  logic [1:0] q;
  int err_count, n_checks, cyc;
  sbs_jtag_model i_ctl (.clk_i(clk), .tdo_i(tdo), .tdo_oe_i(oe),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  sbs_tap_top i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .tck_i(tck),
    .tms_i(tms), .tms_drv_i(tmsd), .tdi_i(tdi), .tdi_drv_i(tdid),
    .tdo_o(tdo), .tdo_oe_o(oe), .pin_i(pin), .mem_float_o(fl),
    .extest_o(ex), .extest_data_o(xd));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask
  // TMS pattern, LSB first, with TDI high
  task automatic walk(logic [7:0] b, int n);
    for (int i = 0; i < n; i++) i_ctl.step(b[i], 1'h1, q);
  endtask
  // From Idle: np TMS bits, shift n bits of d, back to Idle
  task automatic scan(logic [3:0] pre, int np, logic [31:0] d, int n,
      output logic [31:0] r);
    walk(pre, np);
    r = '0;
    for (int i = 0; i < n; i++) begin
      i_ctl.step(i == n - 1, d[i], q);
      r[i] = q[0];
      chk("tdo_oe", 1, q[1]);
    end
    walk(2'h1, 2);
  endtask
  task automatic t_id;
    logic [31:0] r;
    chk("float", 0, fl);
    chk("extest", 0, ex);
    chk("bsr_update", 0, xd);
    walk(8'h0, 1);
    scan(4'h1, 3, 0, 32, r);
    chk("idcode", ID_CODE, r);
    chk("oe_idle", 0, oe);
    $display("t_id done");
  endtask
  task automatic t_codes;
    logic [31:0] r;
    logic [31:0] e;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      scan(4'h3, 4, {29'h0, c}, 3, r);
      chk("ir_capture", IR_CAPTURE, r[1:0]);
      chk("float", c == INS_SAMPLE_Z, fl);
      chk("extest", c == INS_EXTEST, ex);
      case (c)
        INS_EXTEST, INS_SAMPLE_Z, INS_PRELOAD: e = {DAT[0], 4'hF, pin};
        INS_IDCODE: e = ID_CODE[20:0];
        default: e = {DAT[19:0], 1'h0};
      endcase
      scan(4'h1, 3, DAT, 21, r);
      chk("dr_scan", e, r);
      // Update-DR copies the low chain bits; DAT enters bit 0 first
      if (c inside {INS_EXTEST, INS_SAMPLE_Z, INS_PRELOAD})
        chk("bsr_update", DAT[16:1], xd);
    end
    $display("t_codes done");
  endtask
  // Floating lines read as one; reset passes start in Shift-DR so that
  // only Test-Logic-Reset can drop the chain instruction
  task automatic t_pull;
    logic [31:0] r;
    scan(4'h3, 4, 7, 3, r);
    tdid <= 1'h0;
    scan(4'h1, 3, 0, 21, r);
    chk("bypass_float", 32'h1FFFFE, r);
    tdid <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      scan(4'h3, 4, {30'h0, k[0], 1'h0}, 3, r);
      chk("float_set", k[0], fl);
      walk(8'h1, 3);
      tmsd <= k[0];
      walk({8{k[0]}}, 5);
      tmsd <= 1'h1;
      walk(8'h0, 1);
      chk("float_rst", 0, fl);
      chk("extest_rst", 0, ex);
      scan(4'h1, 3, 0, 32, r);
      chk("idcode", ID_CODE, r);
    end
    $display("t_pull done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Run takes about 3700 clocks; twice that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    rst = 1'h1;
    tmsd = 1'h1;
    tdid = 1'h1;
    pin = 16'hC3A5;
    cyc = 0;
    err_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_id;
    t_codes;
    t_pull;
    close_out;
  end
endmodule
